// [dv/dcap_host.sv]
// Upstream host model that sends slot power limit messages.
`timescale 1ns/1ps
module dcap_host (
  input  wire       clk_i,
  output reg        msg_valid_o = 1'h0,
  output reg  [9:0] msg_payload_o = 10'h000
);
  // Payload is inverted once idle so a stale value is never mistaken for a message.
  task send(input [9:0] v);
    @(posedge clk_i);
    msg_valid_o <= 1'h1;
    msg_payload_o <= v;
    @(posedge clk_i);
    msg_valid_o <= 1'h0;
    msg_payload_o <= ~v;
  endtask
endmodule // dcap_host

// [dv/dcap_regs_sva.sv]
// Port assertions for the capabilities register.
`timescale 1ns/1ps
module dcap_sva (
  input wire clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, msg_valid_i,
  input wire [7:0] wb_adr_i,
  input wire [31:0] wb_dat_o,
  input wire [9:0] msg_payload_i,
  input wire [17:0] power_limit_milli_o
);
  reg [9:0] p;
  reg q;
  wire r = q & wb_ack_o;
  // A message at the edge that takes a read always misses that read, which returns the fields from before it.
  always @(posedge clk_i) begin
    p <= rst_i ? 10'h000 : msg_valid_i ? msg_payload_i : p;
    q <= !rst_i & wb_cyc_i & wb_stb_i & !wb_we_i & !wb_ack_o & wb_adr_i == 8'h94;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  chk_unused_zero: assert property (r |-> !{wb_dat_o[31:28], wb_dat_o[17:16], wb_dat_o[14:6]}) else $error("gap");
  chk_scale_load: assert property (r && !$past(msg_valid_i) |-> wb_dat_o[27:26] == p[9:8]) else $error("scale");
  chk_value_load: assert property (r && !$past(msg_valid_i) |-> wb_dat_o[25:18] == p[7:0]) else $error("value");
  chk_limit_hold: assert property (!$past(msg_valid_i, 2) |-> $stable(power_limit_milli_o)) else $error("hold");
  chk_limit_calc: assert property (msg_valid_i ##1 !msg_valid_i |=> power_limit_milli_o ==
    p[7:0] * (p[9:8] == 2'h0 ? 1000 : p[9:8] == 2'h1 ? 100 : p[9:8] == 2'h2 ? 10 : 1)) else $error("limit");
  chk_role_bit: assert property (r |-> wb_dat_o[15]) else $error("role");
  chk_tag_bit: assert property (r |-> !wb_dat_o[5]) else $error("tag");
  chk_phantom_zero: assert property (r |-> wb_dat_o[4:3] == 2'h0) else $error("phantom");
  chk_payload_size: assert property (r |-> wb_dat_o[2:0] == 3'h1) else $error("size");
endmodule // dcap_sva
bind dcap_regs dcap_sva chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_ack_o(wb_ack_o), .msg_valid_i(msg_valid_i), .wb_adr_i(wb_adr_i),
  .wb_dat_o(wb_dat_o), .msg_payload_i(msg_payload_i), .power_limit_milli_o(power_limit_milli_o));

// [dv/device_capabilities_power_limit_capture_test.sv]
// Random self-checking test of the capabilities register.
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin num_errors++; $display("MISMATCH %0t %h %h", $time, a, b); end end
module device_capabilities_power_limit_capture_test;
  reg clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
  reg [7:0] wb_adr_i = 8'h00;
  reg [3:0] wb_sel_i = 4'hF;
  reg [31:0] wb_dat_i = 32'h0, d;
  reg [9:0] v;
  wire [31:0] wb_dat_o;
  wire wb_ack_o, msg_valid_i;
  wire [9:0] msg_payload_i;
  wire [17:0] power_limit_milli_o;
  int num_errors = 0, total_checks = 0, i;
  always #25 clk_i = ~clk_i;
  dcap_regs dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .msg_valid_i(msg_valid_i), .msg_payload_i(msg_payload_i), .power_limit_milli_o(power_limit_milli_o));
  dcap_host host (.clk_i(clk_i), .msg_valid_o(msg_valid_i), .msg_payload_o(msg_payload_i));
  function [31:0] word(input [9:0] x);
    word = {4'h0, x, 3'h1, 15'h0001};
  endfunction
  function [17:0] limit(input [9:0] x);
    limit = x[7:0] * (x[9:8] == 2'h0 ? 1000 : x[9:8] == 2'h1 ? 100 : x[9:8] == 2'h2 ? 10 : 1);
  endfunction
  task wb(input w, input [7:0] a);
    wb_cyc_i <= 1;
    wb_stb_i <= 1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= $urandom;
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1) @(posedge clk_i);
    d = wb_dat_o;
    wb_cyc_i <= 0;
    wb_stb_i <= 0;
    @(posedge clk_i);
  endtask
  task complete_run;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    i = $urandom(19);
    repeat (16) @(posedge clk_i);
    rst_i <= 0;
    wb(0, 8'h94);
    `CHK(d, word(10'h000))
    for (i = 0; i < 24; i++) begin
      v = {i[1:0], 8'($urandom)};
      if (i == 7) v = 10'h3FF;
      host.send(v);
      wb(1, 8'h94);
      wb(0, 8'h94);
      `CHK(d, word(v))
      `CHK(power_limit_milli_o, limit(v))
      wb(0, 8'h98);
      `CHK(d, 32'h0)
    end
    rst_i <= 1;
    repeat (4) @(posedge clk_i);
    rst_i <= 0;
    wb(0, 8'h94);
    `CHK(d, word(10'h000))
    `CHK(power_limit_milli_o, 18'h00000)
    complete_run;
  end
  initial begin
    repeat (3000) @(posedge clk_i);
    num_errors++;
    complete_run;
  end
endmodule // device_capabilities_power_limit_capture_test

// [shared/dcap_consts.vh]
// Constants for the device capabilities register block.
// Functional notes
// - Unused bit ranges read as zero.
// - Message payload 9:8 loads scale field.
// - Scale codes select 1.0 to 0.001 multiplier.
// - Message payload 7:0 loads value field.
// - Power limit is value times scale.
// - Role error reporting bit reads one.
// - Wide tag support bit reads zero.
// - Phantom function bits read zero.
// - Max payload field reads 001b, 256 bytes.
// - Offset 94h, read only, reset 00008001h.
`ifndef DCAP_CONSTS_VH
`define DCAP_CONSTS_VH
`define DCAP_CAP_OFFSET       8'h94
`define DCAP_RESET_VALUE      32'h00008001
`define DCAP_SCALE_HI         27
`define DCAP_SCALE_LO         26
`define DCAP_VALUE_HI         25
`define DCAP_VALUE_LO         18
`define DCAP_ROLE_ERR_BIT     15
`define DCAP_WIDE_TAG_BIT     5
`define DCAP_PHANTOM_HI       4
`define DCAP_PHANTOM_LO       3
`define DCAP_MAX_PAYLOAD_HI   2
`define DCAP_MAX_PAYLOAD_LO   0
`define DCAP_UNUSED_MASK      32'hF0037FC0
`define DCAP_PAYLOAD_SCALE_HI 9
`define DCAP_PAYLOAD_SCALE_LO 8
`define DCAP_PAYLOAD_VALUE_HI 7
`define DCAP_PAYLOAD_VALUE_LO 0
`define DCAP_ROLE_ERR_VAL     1'h1
`define DCAP_WIDE_TAG_VAL     1'h0
`define DCAP_PHANTOM_VAL      2'h0
`define DCAP_MAX_PAYLOAD_VAL  3'h1
`define DCAP_SCALE_RESET      2'h0
`define DCAP_VALUE_RESET      8'h00
`define DCAP_RDATA_RESET      32'h00000000
`define DCAP_UNMAPPED_DATA    32'h00000000
`define DCAP_LIMIT_RESET      18'h00000
`endif

// [verilog/dcap_power_calc.v]
// Slot power limit calculator: value times decimal scale, in milliwatt-like thousandths.
`timescale 1ns/1ps
module dcap_power_calc (
  // Captured fields
  input  wire [1:0]  scale_i,
  input  wire [7:0]  value_i,
  // Limit in units of 0.001 of the value unit
  output reg  [17:0] limit_milli_o
);
  // Scaling to thousandths keeps every code an exact integer product.
  always @* begin
    case (scale_i)
      2'h0:    limit_milli_o = {10'h000, value_i} * 18'h003E8;
      2'h1:    limit_milli_o = {10'h000, value_i} * 18'h00064;
      2'h2:    limit_milli_o = {10'h000, value_i} * 18'h0000A;
      default: limit_milli_o = {10'h000, value_i};
    endcase
  end
endmodule // dcap_power_calc

// [verilog/dcap_regs.v]
// Device capabilities register with captured slot power limit fields.
`timescale 1ns/1ps
`include "dcap_consts.vh"
module dcap_regs (
  // Clock and reset
  input  wire        clk_i,
  input  wire        rst_i,
  // Wishbone slave
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [7:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  // Set_Slot_Power_Limit message from the transaction layer
  input  wire        msg_valid_i,
  input  wire [9:0]  msg_payload_i,
  // Decoded limit
  output reg  [17:0] power_limit_milli_o
);

  // Bus handshake states.
  localparam BUS_IDLE = 2'b00;
  localparam BUS_ACK  = 2'b01;

  // Constant capability fields.
  wire [31:0] unused_bits;
  wire        role_error_report_support;
  wire        wide_tag_support;
  wire [1:0]  phantom_func_support;
  wire [2:0]  max_payload_supported;

  // Captured power limit fields and their next values.
  reg  [1:0]  captured_power_scale;
  reg  [7:0]  captured_power_value;
  reg  [1:0]  next_captured_power_scale;
  reg  [7:0]  next_captured_power_value;

  // Bus side state and next values.
  reg  [1:0]  bus_state;
  reg  [1:0]  next_bus_state;
  reg         next_wb_ack_o;
  reg  [31:0] next_wb_dat_o;
  reg  [17:0] next_power_limit_milli_o;

  // Combinational helpers.
  wire [17:0] limit_calc;
  wire [31:0] cap_word;
  wire        req;
  wire        read_take;
  wire        cap_hit;

  // True when the byte address selects the capabilities register.
  function addr_is_cap;
    input [7:0] adr;
    begin
      addr_is_cap = (adr == `DCAP_CAP_OFFSET);
    end
  endfunction

  // Reserved ranges are cleared last, so no field can ever leak into them.
  function [31:0] assemble_cap;
    input [1:0]  scale;
    input [7:0]  value;
    input        role;
    input        tag;
    input [1:0]  phantom;
    input [2:0]  payload;
    input [31:0] unused;
    begin
      assemble_cap = 32'h00000000;
      assemble_cap[`DCAP_SCALE_HI:`DCAP_SCALE_LO] = scale;
      assemble_cap[`DCAP_VALUE_HI:`DCAP_VALUE_LO] = value;
      assemble_cap[`DCAP_ROLE_ERR_BIT] = role;
      assemble_cap[`DCAP_WIDE_TAG_BIT] = tag;
      assemble_cap[`DCAP_PHANTOM_HI:`DCAP_PHANTOM_LO] = phantom;
      assemble_cap[`DCAP_MAX_PAYLOAD_HI:`DCAP_MAX_PAYLOAD_LO] = payload;
      assemble_cap = assemble_cap & ~unused;
    end
  endfunction

  // Field extraction from the ten payload bits of the message.
  function [1:0] payload_scale;
    input [9:0] payload;
    begin
      payload_scale = payload[`DCAP_PAYLOAD_SCALE_HI:`DCAP_PAYLOAD_SCALE_LO];
    end
  endfunction

  function [7:0] payload_value;
    input [9:0] payload;
    begin
      payload_value = payload[`DCAP_PAYLOAD_VALUE_HI:`DCAP_PAYLOAD_VALUE_LO];
    end
  endfunction

  assign unused_bits               = `DCAP_UNUSED_MASK;
  assign role_error_report_support = `DCAP_ROLE_ERR_VAL;
  assign wide_tag_support          = `DCAP_WIDE_TAG_VAL;
  assign phantom_func_support      = `DCAP_PHANTOM_VAL;
  assign max_payload_supported     = `DCAP_MAX_PAYLOAD_VAL;

  assign req       = wb_cyc_i & wb_stb_i;
  assign read_take = req & ~wb_we_i & (bus_state == BUS_IDLE);
  assign cap_hit   = addr_is_cap(wb_adr_i);
  assign cap_word  = assemble_cap(captured_power_scale,
                                  captured_power_value,
                                  role_error_report_support,
                                  wide_tag_support,
                                  phantom_func_support,
                                  max_payload_supported,
                                  unused_bits);

  // A message replaces both fields in one edge, so a reader never sees a mixed pair.
  always @* begin
    next_captured_power_scale = captured_power_scale;
    next_captured_power_value = captured_power_value;
    if (msg_valid_i) begin
      next_captured_power_scale = payload_scale(msg_payload_i);
      next_captured_power_value = payload_value(msg_payload_i);
    end
  end

  // Field registers.
  always @(posedge clk_i) begin
    if (rst_i) begin
      captured_power_scale <= `DCAP_SCALE_RESET;
      captured_power_value <= `DCAP_VALUE_RESET;
    end else begin
      captured_power_scale <= next_captured_power_scale;
      captured_power_value <= next_captured_power_value;
    end
  end

  // The ack state is a one-cycle guard: a master that keeps its strobe up gets an ack every other cycle.
  always @* begin
    next_bus_state = bus_state;
    case (bus_state)
      BUS_IDLE: begin
        if (req) begin
          next_bus_state = BUS_ACK;
        end
      end
      BUS_ACK: begin
        next_bus_state = BUS_IDLE;
      end
      default: begin
        next_bus_state = BUS_IDLE;
      end
    endcase
  end

  // Ack follows the state that the bus enters.
  always @* begin
    case (next_bus_state)
      BUS_ACK: begin
        next_wb_ack_o = 1'h1;
      end
      default: begin
        next_wb_ack_o = 1'h0;
      end
    endcase
  end

  // Software writes are acknowledged but change nothing; only the message path owns the power fields.
  // Read data holds until the next read, so a slow master can still take it after the ack.
  always @* begin
    next_wb_dat_o = wb_dat_o;
    if (read_take) begin
      if (cap_hit) begin
        next_wb_dat_o = cap_word;
      end else begin
        next_wb_dat_o = `DCAP_UNMAPPED_DATA;
      end
    end
  end

  // The limit trails the fields by one edge; a read straight after a message sees the fields first.
  always @* begin
    next_power_limit_milli_o = limit_calc;
  end

  // Bus state register.
  always @(posedge clk_i) begin
    if (rst_i) begin
      bus_state <= BUS_IDLE;
    end else begin
      bus_state <= next_bus_state;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'h0;
    end else begin
      wb_ack_o <= next_wb_ack_o;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= `DCAP_RDATA_RESET;
    end else begin
      wb_dat_o <= next_wb_dat_o;
    end
  end

  // Limit register.
  always @(posedge clk_i) begin
    if (rst_i) begin
      power_limit_milli_o <= `DCAP_LIMIT_RESET;
    end else begin
      power_limit_milli_o <= next_power_limit_milli_o;
    end
  end

  // The multiplier sits in its own module so the arithmetic can change without touching the bus side.
  dcap_power_calc u_calc (
    .scale_i       (captured_power_scale),
    .value_i       (captured_power_value),
    .limit_milli_o (limit_calc)
  );
endmodule // dcap_regs
